//--- src/lfr_pkg.sv
// package: register map, field positions and timing of the fault bank
package lfr_pkg;
    // register byte offsets on the parallel byte-wide register port
    localparam logic [7:0] ADDR_CMD = 8'h01;
    localparam logic [7:0] ADDR_GENERAL_FAULT_STATUS = 8'h02;
    localparam logic [7:0] ADDR_LEFT_FAULT_STATUS = 8'h03;
    localparam logic [7:0] ADDR_RIGHT_FAULT_STATUS = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h05;
    localparam logic [7:0] ADDR_GENERAL_FAULT_ENABLE = 8'h06;
    // reset value of every writable or sticky byte
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // writable bits of the command and general enable registers
    localparam logic [7:0] CMD_WMASK = 8'hc0;
    localparam logic [7:0] GEN_WMASK = 8'h70;
    // command register bit positions
    localparam int CMD_RIGHT_RESTART = 7;
    localparam int CMD_LEFT_RESTART = 6;
    // general fault and enable bit positions (same in both)
    localparam int GEN_THERMAL_WARNING = 6;
    localparam int GEN_THERMAL_SHUTDOWN = 5;
    localparam int GEN_OVERV = 4;
    // index of each channel fault type in a 5-bit vector
    localparam int CH_SUPPLY = 4;
    localparam int CH_GROUND = 3;
    localparam int CH_OVERCUR = 2;
    localparam int CH_OFFSET = 1;
    localparam int CH_OPEN = 0;
    localparam int CH_W = 5;
    // summary status bit positions
    localparam int ST_FLAG = 7;
    localparam int ST_LFLOAT = 6;
    localparam int ST_RFLOAT = 5;
    localparam int ST_LOFF = 4;
    localparam int ST_ROFF = 3;
    // charge-pump frequency codes
    localparam logic [1:0] PUMP_SEL_333 = 2'b00;
    localparam logic [1:0] PUMP_SEL_190 = 2'b01;
    localparam logic [1:0] PUMP_SEL_426 = 2'b10;
    localparam logic [1:0] PUMP_SEL_260 = 2'b11;
    // system clock rate in Hz and pump frequencies in kHz
    localparam int CLK_HZ = 125_000_000;
    localparam int PUMP_KHZ_333 = 333;
    localparam int PUMP_KHZ_190 = 190;
    localparam int PUMP_KHZ_426 = 426;
    localparam int PUMP_KHZ_260 = 260;
    // half period of the pump clock in system cycles
    localparam int PUMP_CNT_W = 9;
    localparam int HALF_333 = CLK_HZ / (2 * PUMP_KHZ_333 * 1000);
    localparam int HALF_190 = CLK_HZ / (2 * PUMP_KHZ_190 * 1000);
    localparam int HALF_426 = CLK_HZ / (2 * PUMP_KHZ_426 * 1000);
    localparam int HALF_260 = CLK_HZ / (2 * PUMP_KHZ_260 * 1000);

    // places a channel fault vector into its register byte
    function automatic logic [7:0] ch_byte(input logic [CH_W-1:0] f);
        ch_byte = {f[CH_SUPPLY], f[CH_GROUND], f[CH_OVERCUR], 1'b0,
                   f[CH_OFFSET], f[CH_OPEN], 2'b00};
    endfunction
endpackage

//--- src/lfr_sync.sv
// three-stage input synchroniser with second/third stage agreement
`timescale 1ns/100ps
module lfr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] ff1_reg; // first stage, read only by ff2
    logic [W-1:0] ff2_reg; // second stage
    logic [W-1:0] ff3_reg; // third stage
    logic [W-1:0] out_reg; // filtered level

    // shift chain
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ff1_reg <= '0;
            ff2_reg <= '0;
            ff3_reg <= '0;
        end else begin
            ff1_reg <= async_in;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
        end
    end

    // a bit changes only when stages two and three agree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_reg <= '0;
        end else begin
            out_reg <= (ff2_reg & ff3_reg) | (out_reg & (ff2_reg | ff3_reg));
        end
    end

    assign sync_out = out_reg;
endmodule

//--- src/lfr_chan.sv
// one audio channel: sticky fault bits, shutdown and restart
`timescale 1ns/100ps
module lfr_chan (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [lfr_pkg::CH_W-1:0] det_async,
    input wire logic [lfr_pkg::CH_W-1:0] fault_enable,
    input wire logic diagnostic_mode_on,
    input wire logic restart,
    input wire logic read_clear,
    output logic [lfr_pkg::CH_W-1:0] fault_status,
    output logic amp_on,
    output logic offset_live
);
    logic [lfr_pkg::CH_W-1:0] det_s; // synchronised detector levels
    logic [lfr_pkg::CH_W-1:0] hit; // qualified detections
    logic short_hit; // short to supply or ground
    logic [lfr_pkg::CH_W-1:0] status_reg; // sticky fault bits
    logic amp_off_reg; // amplifier held off
    logic offset_reg; // live offset detection

    lfr_sync #(.W(lfr_pkg::CH_W)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(det_async),
        .sync_out(det_s)
    );

    // detection needs diagnostic mode and the type enable
    assign hit = det_s & fault_enable & {lfr_pkg::CH_W{diagnostic_mode_on}};
    assign short_hit = hit[lfr_pkg::CH_SUPPLY] | hit[lfr_pkg::CH_GROUND];

    // sticky bits; a new detection wins over clear on read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_reg <= '0;
        end else if (read_clear) begin
            status_reg <= hit;
        end else begin
            status_reg <= status_reg | hit;
        end
    end

    // a short turns the amplifier off until restart is written
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            amp_off_reg <= 1'b0;
        end else if (short_hit) begin
            amp_off_reg <= 1'b1;
        end else if (restart) begin
            amp_off_reg <= 1'b0;
        end
    end

    // live offset mirror for the summary register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            offset_reg <= 1'b0;
        end else begin
            offset_reg <= hit[lfr_pkg::CH_OFFSET];
        end
    end

    assign fault_status = status_reg;
    assign amp_on = ~amp_off_reg;
    assign offset_live = offset_reg;

    property p_short_off;
        @(posedge clk) disable iff (sys_rst) short_hit |=> !amp_on;
    endproperty
    a_short_off: assert property (p_short_off)
        else $error("amplifier stayed on after a short");

    property p_restart_on;
        @(posedge clk) disable iff (sys_rst)
            (restart && !short_hit) |=> amp_on;
    endproperty
    a_restart_on: assert property (p_restart_on)
        else $error("restart did not turn the amplifier on");

    property p_clear;
        @(posedge clk) disable iff (sys_rst)
            (read_clear && hit == '0) |=> fault_status == '0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("fault bits not cleared by read");

    property p_set;
        @(posedge clk) disable iff (sys_rst)
            hit != '0 |=> (fault_status & $past(hit)) == $past(hit);
    endproperty
    a_set: assert property (p_set)
        else $error("detected fault not recorded");
endmodule

//--- src/lfr_top.sv
// diagnostic and command register bank of the line driver
//
// Contract
// - pump code selects 333, 190, 426, 260 kHz
// - right retry bit turns right amplifier on
// - left retry bit turns left amplifier on
// - thermal warning sets general bit six
// - thermal shutdown sets general bit five
// - overvoltage sets general bit four
// - general faults need their enable bit set
// - left faults set their left register bits
// - left faults need their left enable bit
// - any left fault pulls fault pin low
// - right faults set their right register bits
// - right faults need their right enable bit
// - any right fault pulls fault pin low
// - status bit seven mirrors low fault pin
// - status bits six, five show floating outputs
// - status bits four, three mirror offset faults
// - status bits two to zero: device type
// - reading a channel fault register clears it
// - short switches channel off until retry
// - diagnosis needs diagnostic mode and enable
`timescale 1ns/100ps
module lfr_top #(
    // device type code; value is arbitrary
    parameter logic [2:0] DEVICE_TYPE_CODE = 3'h2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic diagnostic_mode,
    input wire logic [1:0] pump_freq_sel,
    input wire logic [7:0] left_fault_enable,
    input wire logic [7:0] right_fault_enable,
    input wire logic thermal_warning,
    input wire logic thermal_shutdown,
    input wire logic overvoltage,
    input wire logic [4:0] left_fault_det,
    input wire logic [4:0] right_fault_det,
    output logic left_amp_on,
    output logic right_amp_on,
    output logic left_output_floating,
    output logic right_output_floating,
    output logic pump_clk,
    output logic fault_flag_n_out,
    output logic fault_flag_n_oe
);
    // command register, only retry bits kept
    logic [7:0] cmd_reg;
    // general fault enable register
    logic [7:0] gen_enable_reg;
    // general fault status bits, following the gated detectors
    logic [7:0] gen_status_reg;
    // read data and valid
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    // fault pin drive enable
    logic flag_oe_reg;
    // amplifier and floating output copies
    logic left_on_reg;
    logic right_on_reg;
    logic left_float_reg; // left output floating, registered
    logic right_float_reg; // right output floating, registered
    // pump divider
    logic [lfr_pkg::PUMP_CNT_W-1:0] pump_cnt_reg;
    logic [lfr_pkg::PUMP_CNT_W-1:0] pump_half;
    logic pump_reg;
    // synchronised general detector levels
    logic [2:0] gen_det_s;
    // qualified general detections
    logic [7:0] gen_hit;
    // decoded bus strobes
    logic wr_cmd;
    logic wr_general_fault_enable;
    logic rd_left;
    logic rd_right;
    logic left_restart;
    logic right_restart;
    // channel results
    logic [lfr_pkg::CH_W-1:0] left_status;
    logic [lfr_pkg::CH_W-1:0] right_status;
    logic left_on;
    logic right_on;
    logic left_offset;
    logic right_offset;
    logic [7:0] left_byte;
    logic [7:0] right_byte;
    logic [7:0] status_byte;
    logic [7:0] rd_mux;
    logic any_fault;

    // general detectors come from analog comparators
    lfr_sync #(.W(3)) u_gen_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in({thermal_warning, thermal_shutdown, overvoltage}),
        .sync_out(gen_det_s)
    );

    // write and read strobes by address
    always_comb begin
        wr_cmd = 1'b0;
        wr_general_fault_enable = 1'b0;
        rd_left = 1'b0;
        rd_right = 1'b0;
        if (reg_wr && reg_addr == lfr_pkg::ADDR_CMD) begin
            wr_cmd = 1'b1;
        end else if (reg_wr && reg_addr == lfr_pkg::ADDR_GENERAL_FAULT_ENABLE) begin
            wr_general_fault_enable = 1'b1;
        end
        if (reg_rd && reg_addr == lfr_pkg::ADDR_LEFT_FAULT_STATUS) begin
            rd_left = 1'b1;
        end else if (reg_rd && reg_addr == lfr_pkg::ADDR_RIGHT_FAULT_STATUS) begin
            rd_right = 1'b1;
        end
    end

    // a write of one to a retry bit restarts that amplifier
    assign right_restart = wr_cmd &
        reg_wdata[lfr_pkg::CMD_RIGHT_RESTART];
    assign left_restart = wr_cmd &
        reg_wdata[lfr_pkg::CMD_LEFT_RESTART];

    // left channel
    lfr_chan u_left (
        .clk(clk),
        .sys_rst(sys_rst),
        .det_async(left_fault_det),
        .fault_enable({left_fault_enable[7:5], left_fault_enable[3:2]}),
        .diagnostic_mode_on(diagnostic_mode),
        .restart(left_restart),
        .read_clear(rd_left),
        .fault_status(left_status),
        .amp_on(left_on),
        .offset_live(left_offset)
    );

    // right channel
    lfr_chan u_right (
        .clk(clk),
        .sys_rst(sys_rst),
        .det_async(right_fault_det),
        .fault_enable({right_fault_enable[7:5], right_fault_enable[3:2]}),
        .diagnostic_mode_on(diagnostic_mode),
        .restart(right_restart),
        .read_clear(rd_right),
        .fault_status(right_status),
        .amp_on(right_on),
        .offset_live(right_offset)
    );

    // command register keeps only the retry bits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_reg <= lfr_pkg::RESET_BYTE;
        end else if (wr_cmd) begin
            cmd_reg <= reg_wdata & lfr_pkg::CMD_WMASK;
        end
    end

    // general enable register, bits outside the enables drop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gen_enable_reg <= lfr_pkg::RESET_BYTE;
        end else if (wr_general_fault_enable) begin
            gen_enable_reg <= reg_wdata & lfr_pkg::GEN_WMASK;
        end
    end

    // general detections gated by mode and enable
    always_comb begin
        gen_hit = lfr_pkg::RESET_BYTE;
        gen_hit[lfr_pkg::GEN_THERMAL_WARNING] = gen_det_s[2];
        gen_hit[lfr_pkg::GEN_THERMAL_SHUTDOWN] = gen_det_s[1];
        gen_hit[lfr_pkg::GEN_OVERV] = gen_det_s[0];
        gen_hit = gen_hit & gen_enable_reg & {8{diagnostic_mode}};
    end

    // general bits follow the detector while it is enabled
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gen_status_reg <= lfr_pkg::RESET_BYTE;
        end else begin
            gen_status_reg <= gen_hit;
        end
    end

    // register views of the channel vectors
    assign left_byte = lfr_pkg::ch_byte(left_status);
    assign right_byte = lfr_pkg::ch_byte(right_status);
    assign any_fault = (left_status != '0) | (right_status != '0) |
                       (gen_status_reg != lfr_pkg::RESET_BYTE);

    // fault pin pulled low while any fault bit stands
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_oe_reg <= 1'b0;
        end else begin
            flag_oe_reg <= any_fault;
        end
    end

    // summary status byte
    always_comb begin
        status_byte = lfr_pkg::RESET_BYTE;
        status_byte[lfr_pkg::ST_FLAG] = flag_oe_reg;
        status_byte[lfr_pkg::ST_LFLOAT] = ~left_on_reg;
        status_byte[lfr_pkg::ST_RFLOAT] = ~right_on_reg;
        status_byte[lfr_pkg::ST_LOFF] = left_offset;
        status_byte[lfr_pkg::ST_ROFF] = right_offset;
        status_byte[2:0] = DEVICE_TYPE_CODE;
    end

    // read decode; unmapped addresses read zero
    always_comb begin
        if (reg_addr == lfr_pkg::ADDR_CMD) begin
            rd_mux = cmd_reg;
        end else if (reg_addr == lfr_pkg::ADDR_GENERAL_FAULT_STATUS) begin
            rd_mux = gen_status_reg;
        end else if (reg_addr == lfr_pkg::ADDR_LEFT_FAULT_STATUS) begin
            rd_mux = left_byte;
        end else if (reg_addr == lfr_pkg::ADDR_RIGHT_FAULT_STATUS) begin
            rd_mux = right_byte;
        end else if (reg_addr == lfr_pkg::ADDR_STATUS) begin
            rd_mux = status_byte;
        end else if (reg_addr == lfr_pkg::ADDR_GENERAL_FAULT_ENABLE) begin
            rd_mux = gen_enable_reg;
        end else begin
            rd_mux = lfr_pkg::RESET_BYTE;
        end
    end

    // read data captured on the read strobe, valid one cycle later
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_reg <= lfr_pkg::RESET_BYTE;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_rd;
            if (reg_rd) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // registered amplifier state for the top outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            left_on_reg <= 1'b1;
            right_on_reg <= 1'b1;
            left_float_reg <= 1'b0;
            right_float_reg <= 1'b0;
        end else begin
            left_on_reg <= left_on;
            right_on_reg <= right_on;
            left_float_reg <= ~left_on;
            right_float_reg <= ~right_on;
        end
    end

    // half period for the selected pump frequency
    always_comb begin
        case (pump_freq_sel)
            lfr_pkg::PUMP_SEL_333: begin
                pump_half = lfr_pkg::PUMP_CNT_W'(lfr_pkg::HALF_333);
            end
            lfr_pkg::PUMP_SEL_190: begin
                pump_half = lfr_pkg::PUMP_CNT_W'(lfr_pkg::HALF_190);
            end
            lfr_pkg::PUMP_SEL_426: begin
                pump_half = lfr_pkg::PUMP_CNT_W'(lfr_pkg::HALF_426);
            end
            default: begin
                pump_half = lfr_pkg::PUMP_CNT_W'(lfr_pkg::HALF_260);
            end
        endcase
    end

    // pump clock divider toggles every half period
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pump_cnt_reg <= '0;
            pump_reg <= 1'b0;
        end else if (pump_cnt_reg + 1'b1 >= pump_half) begin
            pump_cnt_reg <= '0;
            pump_reg <= ~pump_reg;
        end else begin
            pump_cnt_reg <= pump_cnt_reg + 1'b1;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign left_amp_on = left_on_reg;
    assign right_amp_on = right_on_reg;
    assign left_output_floating = left_float_reg;
    assign right_output_floating = right_float_reg;
    assign pump_clk = pump_reg;
    assign fault_flag_n_out = 1'b0;
    assign fault_flag_n_oe = flag_oe_reg;

    property p_flag_left;
        @(posedge clk) disable iff (sys_rst)
            left_status != '0 |=> fault_flag_n_oe;
    endproperty
    a_flag_left: assert property (p_flag_left)
        else $error("left fault did not pull the fault pin");

    property p_flag_right;
        @(posedge clk) disable iff (sys_rst)
            right_status != '0 |=> fault_flag_n_oe;
    endproperty
    a_flag_right: assert property (p_flag_right)
        else $error("right fault did not pull the fault pin");

    property p_status_flag;
        @(posedge clk) disable iff (sys_rst)
            (reg_rd && reg_addr == lfr_pkg::ADDR_STATUS) |=>
            reg_rdata[lfr_pkg::ST_FLAG] == $past(fault_flag_n_oe);
    endproperty
    a_status_flag: assert property (p_status_flag)
        else $error("status flag bit differs from fault pin");

    property p_type_code;
        @(posedge clk) disable iff (sys_rst)
            (reg_rd && reg_addr == lfr_pkg::ADDR_STATUS) |=>
            reg_rdata[2:0] == DEVICE_TYPE_CODE;
    endproperty
    a_type_code: assert property (p_type_code)
        else $error("device type code wrong");

    property p_unmapped;
        @(posedge clk) disable iff (sys_rst)
            (reg_rd && (reg_addr == 8'h00 || reg_addr > 8'h06)) |=>
            reg_rvalid && reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_gen_gate;
        @(posedge clk) disable iff (sys_rst)
            !diagnostic_mode |=> gen_status_reg == 8'h00;
    endproperty
    a_gen_gate: assert property (p_gen_gate)
        else $error("general fault set outside diagnostic mode");

    property p_right_restart;
        @(posedge clk) disable iff (sys_rst)
            (right_restart && right_fault_det == 5'h00 && right_on == 1'b0
             && $stable(right_fault_det)) |=> ##1 right_amp_on;
    endproperty
    a_right_restart: assert property (p_right_restart)
        else $error("right retry write did not restart amplifier");

    property p_pump_hold;
        @(posedge clk) disable iff (sys_rst)
            (pump_cnt_reg + 1'b1 < pump_half) |=> $stable(pump_clk);
    endproperty
    a_pump_hold: assert property (p_pump_hold)
        else $error("pump clock toggled before its half period");
endmodule

//--- testbench/lfr_host_model.sv
// host model: register port master issuing single-byte reads and writes
`timescale 1ns/100ps
module lfr_host_model (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    // bus idle from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one-cycle write; a one in a retry bit restarts that amp
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        // released address and data no longer show the last value
        reg_wdata = ~d;
        reg_addr = ~a;
    endtask

    // one-cycle read; data only counts when the answer pulse is up
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rvalid === 1'b1 ? reg_rdata : 8'hxx;
    endtask
endmodule

//--- testbench/lfr_top_tb.sv
// self-checking bench for the fault register bank
`timescale 1ns/100ps
module lfr_top_tb;
    // arbitrary device type code for this run
    localparam logic [2:0] DTC = 3'h3;
    logic clk = 1'b0, sys_rst = 1'b1, diagnostic_mode = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, reg_rvalid;
    logic [1:0] pump_freq_sel = 2'b00;
    logic [7:0] lfe = 8'h00, rfe = 8'h00;
    logic [2:0] gen = 3'h0;
    logic [4:0] ldet = 5'h00, rdet = 5'h00;
    logic left_amp_on, right_amp_on, lfl, rfl, pump_clk, fl_out, fl_oe;
    int num_errors = 0, compares = 0, cycles = 0;

    lfr_top #(.DEVICE_TYPE_CODE(DTC)) DUT (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .diagnostic_mode(diagnostic_mode), .pump_freq_sel(pump_freq_sel),
        .left_fault_enable(lfe), .right_fault_enable(rfe),
        .thermal_warning(gen[2]), .thermal_shutdown(gen[1]),
        .overvoltage(gen[0]), .left_fault_det(ldet), .right_fault_det(rdet),
        .left_amp_on(left_amp_on), .right_amp_on(right_amp_on),
        .left_output_floating(lfl), .right_output_floating(rfl),
        .pump_clk(pump_clk), .fault_flag_n_out(fl_out),
        .fault_flag_n_oe(fl_oe));

    lfr_host_model host (.clk(clk), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    // 125 MHz system clock
    always #4 clk = ~clk;

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // the one compare task
    task automatic chk(input logic [15:0] got, exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read a register and compare the byte
    task automatic rchk(input logic [7:0] a, exp);
        logic [7:0] d;
        host.rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask

    // wait whole cycles
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // reset values, unmapped place
    task automatic t_reset();
        for (int a = 1; a < 7; a++) begin
            rchk(a[7:0], a == 5 ? {5'h00, DTC} : 8'h00);
        end
        rchk(8'h20, 8'h00);
        $display("test reset done");
    endtask

    // unused and read-only bits
    task automatic t_regs();
        host.wr(8'h01, 8'hff);
        rchk(8'h01, 8'hc0);
        host.wr(8'h06, 8'hff);
        rchk(8'h06, 8'h70);
        host.wr(8'h05, 8'hff);
        rchk(8'h05, {5'h00, DTC});
        $display("test regs done");
    endtask

    // general faults, enable and diagnostic_mode gating
    task automatic t_general();
        diagnostic_mode = 1'b1;
        for (int i = 0; i < 3; i++) begin
            gen = 3'h4 >> i;
            cyc(8);
            rchk(8'h02, 8'h40 >> i);
        end
        gen = 3'h7;
        host.wr(8'h06, 8'h00);
        cyc(8);
        rchk(8'h02, 8'h00);
        host.wr(8'h06, 8'h70);
        diagnostic_mode = 1'b0;
        cyc(8);
        rchk(8'h02, 8'h00);
        gen = 3'h0;
        diagnostic_mode = 1'b1;
        cyc(8);
        $display("test general done");
    endtask

    // left short: off, sticky, clear on read, retry
    task automatic t_left();
        ldet = 5'h1f;
        cyc(8);
        rchk(8'h03, 8'h00);
        lfe = 8'h80;
        ldet = 5'h10;
        cyc(8);
        chk(left_amp_on, 1'b0);
        chk(lfl, 1'b1);
        chk(fl_oe, 1'b1);
        chk(fl_out, 1'b0);
        rchk(8'h05, {5'h18, DTC});
        ldet = 5'h00;
        cyc(8);
        rchk(8'h03, 8'h80);
        rchk(8'h03, 8'h00);
        chk(left_amp_on, 1'b0);
        host.wr(8'h01, 8'h40);
        cyc(3);
        chk(left_amp_on, 1'b1);
        chk(lfl, 1'b0);
        rchk(8'h05, {5'h00, DTC});
        $display("test left done");
    endtask

    // every right fault type, offset mirror, retry
    task automatic t_right();
        logic [7:0] e;
        rdet = 5'h1f;
        cyc(8);
        rchk(8'h04, 8'h00);
        // drain the masked levels before the enables open
        rdet = 5'h00;
        cyc(8);
        rfe = 8'hec;
        for (int i = 0; i < 5; i++) begin
            e = 8'h00;
            e[i > 1 ? i + 3 : i + 2] = 1'b1;
            rdet = 5'h01 << i;
            cyc(8);
            chk(fl_oe, 1'b1);
            chk(right_amp_on, i < 3);
            chk(rfl, i > 2);
            if (i == 1) rchk(8'h05, {5'h11, DTC});
            rdet = 5'h00;
            cyc(8);
            rchk(8'h04, e);
            host.wr(8'h01, 8'h80);
            cyc(3);
            chk(right_amp_on, 1'b1);
            chk(rfl, 1'b0);
            chk(fl_oe, 1'b0);
        end
        diagnostic_mode = 1'b0;
        rdet = 5'h1f;
        cyc(8);
        rchk(8'h04, 8'h00);
        rdet = 5'h00;
        $display("test right done");
    endtask

    // pump half period for every code
    task automatic t_pump();
        int half[4] = '{187, 328, 146, 240};
        int n;
        for (int c = 0; c < 4; c++) begin
            pump_freq_sel = c[1:0];
            @(posedge pump_clk);
            @(negedge pump_clk);
            // step off the launching edge so the count is whole cycles
            @(negedge clk);
            n = 0;
            while (pump_clk !== 1'b1) begin
                @(negedge clk);
                n++;
            end
            chk(n[15:0], half[c][15:0]);
        end
        $display("test pump done");
    endtask

    // counts and verdict
    task automatic tally_and_finish();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
        t_regs();
        t_general();
        t_left();
        t_right();
        t_pump();
        tally_and_finish();
    end
endmodule
